// ==== design/acs_pkg.sv ====
// What this block does
// - Clear enable and power, re-set, restart recovers a halt or a stuck start; a hang needs reset.
// - Power toggled while a conversion runs halts every mode but single, sequence included.
// - Select field 11 picks the subsystem clock.
// - Leaving gated subclock at odd divider hangs.
// - Enable and start together after hardware trigger stick.
package acs_pkg;
	// ==========================================================
	// Register map
	localparam logic [11:0] ACS_CTRL_ADDR   = 12'h000;
	localparam logic [11:0] ACS_CLK_ADDR    = 12'h004;
	localparam logic [11:0] ACS_STATUS_ADDR = 12'h008;
	localparam logic [11:0] ACS_RESULT_ADDR = 12'h00C;
	// CTRL fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_POWER_BIT  = 1;
	localparam int CTRL_START_BIT  = 2;
	localparam int CTRL_SHP_BIT    = 3;
	localparam int CTRL_MODE_LSB   = 4;
	localparam int CTRL_TRIG_BIT   = 6;
	localparam int CTRL_CHAN_LSB   = 8;
	// CLK fields
	localparam int CLK_SEL_LSB     = 0;
	localparam int CLK_DIV_LSB     = 4;
	localparam int CLK_GATE_BIT    = 8;
	// STATUS fields
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_HALT_BIT   = 1;
	localparam int STAT_HANG_BIT   = 2;
	localparam int STAT_STUCK_BIT  = 3;
	localparam int STAT_CHAN_LSB   = 8;
	// Field values
	localparam logic [1:0] CLK_SEL_SUBSYS = 2'h3;
	localparam logic [2:0] CTRL_RESET     = 3'h0;
	localparam logic [31:0] WORD_ZERO     = 32'h00000000;
	// Timing in converter clock ticks
	localparam int SAMPLE_TICKS  = 4;
	localparam int CONVERT_TICKS = 13;
	localparam logic [4:0] SAMPLE_CNT  = 5'(SAMPLE_TICKS);
	localparam logic [4:0] CONVERT_CNT = 5'(CONVERT_TICKS);
	localparam logic [3:0] LAST_CHAN   = 4'hF;
	typedef enum logic [1:0]
	{
		ACS_SINGLE,
		ACS_SEQUENCE,
		ACS_REPEAT_SINGLE,
		ACS_REPEAT_SEQUENCE
	} acs_mode_t;
	typedef enum
	{
		ACS_IDLE,
		ACS_SAMPLE,
		ACS_CONVERT,
		ACS_WRITE
	} acs_state_t;
	function automatic logic acs_odd_div(input logic [2:0] div);
		// Divider code n means divide by n+1; /3,/5,/7 are codes 2,4,6.
		acs_odd_div = (div == 3'h2) || (div == 3'h4) || (div == 3'h6);
	endfunction : acs_odd_div
endpackage : acs_pkg

// ==== design/acs_tick_if.sv ====
`timescale 1ns/1ps
interface acs_tick_if;
	logic [1:0] sel;
	logic [2:0] div;
	logic       gate_off;
	logic       tick;
	logic       hang;
	modport gen
	(
		input  sel,
		input  div,
		input  gate_off,
		output tick,
		output hang
	);
	modport use_side
	(
		output sel,
		output div,
		output gate_off,
		input  tick,
		input  hang
	);
endinterface : acs_tick_if

// ==== design/acs_clkgen.sv ====
`timescale 1ns/1ps
module acs_clkgen
	import acs_pkg::*;
(
	input wire logic pclk,    // Bus clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic sub_en,  // Subsystem clock enable pulse.
	input wire logic alt_en,  // Alternate source enable pulse.
	acs_tick_if.gen  tk       // Converter tick and selection.
);
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic       hang;
	logic       next_hang;
	logic [1:0] sel_q;
	logic [1:0] next_sel_q;
	logic       tick;
	logic       next_tick;
	logic       src_en;

	// ==========================================================
	// Source select and divider
	always_comb
	begin
		src_en = (tk.sel == CLK_SEL_SUBSYS) ? (sub_en && !tk.gate_off) : alt_en;
		next_cnt  = cnt;
		next_tick = 1'b0;
		next_sel_q = tk.sel;
		next_hang = hang;
		// Switching away from a gated subsystem clock at an odd divide latches the hang.
		if (sel_q == CLK_SEL_SUBSYS && tk.sel != CLK_SEL_SUBSYS && tk.gate_off && acs_odd_div(tk.div))
			next_hang = 1'b1;
		if (src_en && !hang)
		begin
			if (cnt >= tk.div)
			begin
				next_cnt  = 3'h0;
				next_tick = 1'b1;
			end
			else
				next_cnt = cnt + 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt   <= 3'h0;
			tick  <= 1'b0;
			hang  <= 1'b0;
			sel_q <= 2'h0;
		end
		else
		begin
			cnt   <= next_cnt;
			tick  <= next_tick;
			hang  <= next_hang;
			sel_q <= next_sel_q;
		end
	end

	assign tk.tick = tick;
	assign tk.hang = hang;
endmodule : acs_clkgen

// ==== design/acs_sequencer.sv ====
`timescale 1ns/1ps
module acs_sequencer
	import acs_pkg::*;
(
	input  wire logic        pclk,      // Bus clock, 10 MHz.
	input  wire logic        presetn,   // Asynchronous reset, active low.
	input  wire logic        psel,      // APB select.
	input  wire logic        penable,   // APB enable.
	input  wire logic        pwrite,    // APB direction.
	input  wire logic [11:0] paddr,     // APB byte address.
	input  wire logic [31:0] pwdata,    // APB write data.
	output logic      [31:0] prdata,    // APB read data.
	output logic             pready,    // APB ready.
	output logic             pslverr,   // APB error.
	input  wire logic        sub_en,    // Subsystem clock enable pulse.
	input  wire logic        alt_en,    // Alternate clock enable pulse.
	input  wire logic        timer_trig, // Timer trigger pin, asynchronous.
	input  wire logic [11:0] adc_data,  // Analog core result.
	output logic             sample_on, // Sample switch closed.
	output logic             conv_done  // Result written pulse.
);
	acs_tick_if tk ();

	// Control registers.
	logic        conv_enable_bit;
	logic        converter_power_bit;
	logic        software_start_bit;
	logic        sample_pulse_select;
	logic        trig_timer;
	logic [1:0]  conversion_sequence_mode;
	logic [3:0]  end_chan;
	logic [1:0]  converter_clock_select;
	logic [2:0]  converter_clock_divider;
	logic        subclock_gate_off;
	logic        next_en;
	logic        next_pw;
	logic        next_sc;
	logic        sc_wr;
	logic        next_shp;
	logic        next_trig;
	logic        next_gate;
	logic [1:0]  next_mode;
	logic [1:0]  next_sel;
	logic [3:0]  next_end;
	logic [2:0]  next_div;
	// Sequencer state.
	acs_state_t  state;
	acs_state_t  next_state;
	logic [4:0]  cnt;
	logic [4:0]  next_cnt;
	logic [3:0]  chan;
	logic [3:0]  next_chan;
	logic        halted;
	logic        next_halted;
	logic        stuck;
	logic        next_stuck;
	logic        hw_used;
	logic        next_hw_used;
	logic        armed;
	logic        next_armed;
	logic [11:0] result;
	logic [11:0] next_result;
	logic       next_sample_on, next_conv_done;
	logic [31:0] next_prdata;
	logic       next_pslverr;
	// Trigger synchroniser.
	logic [2:0] trig_sync;
	logic       trig_level, next_trig_level;
	logic       trig_rise;

	logic        wr;
	logic        rd;
	logic        busy;
	logic        pw_toggle;
	logic        repeat_mode;
	logic        start_req;

	acs_clkgen u_clk
	(
		.pclk    (pclk),
		.presetn (presetn),
		.sub_en  (sub_en),
		.alt_en  (alt_en),
		.tk      (tk.gen)
	);
	assign tk.sel      = converter_clock_select;
	assign tk.div      = converter_clock_divider;
	assign tk.gate_off = subclock_gate_off;

	// ==========================================================
	// Register bus
	always_comb
	begin
		wr = psel && penable && pwrite;
		// Read data and the error flag are decoded in the setup cycle so that they stand beside pready.
		rd = psel && !penable && !pwrite;
		busy = (state != ACS_IDLE) || stuck;
		next_en = conv_enable_bit;
		next_pw = converter_power_bit;
		next_shp = sample_pulse_select;
		next_trig = trig_timer;
		next_mode = conversion_sequence_mode;
		next_end = end_chan;
		next_sel = converter_clock_select;
		next_div = converter_clock_divider;
		next_gate = subclock_gate_off;
		sc_wr = software_start_bit;
		pw_toggle = 1'b0;
		next_prdata = WORD_ZERO;
		next_pslverr = 1'b0;
		if (wr && paddr == ACS_CTRL_ADDR)
		begin
			next_en = pwdata[CTRL_ENABLE_BIT];
			next_pw = pwdata[CTRL_POWER_BIT];
			sc_wr = software_start_bit || pwdata[CTRL_START_BIT];
			pw_toggle = pwdata[CTRL_POWER_BIT] != converter_power_bit;
			// Mode fields are only writable while conversions are disabled.
			if (!conv_enable_bit)
			begin
				next_shp  = pwdata[CTRL_SHP_BIT];
				next_mode = pwdata[CTRL_MODE_LSB +: 2];
				next_trig = pwdata[CTRL_TRIG_BIT];
				next_end  = pwdata[CTRL_CHAN_LSB +: 4];
			end
		end
		if (wr && paddr == ACS_CLK_ADDR)
		begin
			next_sel  = pwdata[CLK_SEL_LSB +: 2];
			next_div  = pwdata[CLK_DIV_LSB +: 3];
			next_gate = pwdata[CLK_GATE_BIT];
		end
		if (psel && !penable && !(paddr == ACS_CTRL_ADDR || paddr == ACS_CLK_ADDR
			|| paddr == ACS_STATUS_ADDR || paddr == ACS_RESULT_ADDR))
			next_pslverr = 1'b1;
		if (rd)
		begin
			case (paddr)
				ACS_CTRL_ADDR: next_prdata = {20'h0, end_chan, 1'b0, trig_timer, conversion_sequence_mode,
					sample_pulse_select, software_start_bit, converter_power_bit, conv_enable_bit};
				ACS_CLK_ADDR: next_prdata = {23'h0, subclock_gate_off, 1'b0, converter_clock_divider,
					2'h0, converter_clock_select};
				ACS_STATUS_ADDR: next_prdata = {20'h0, chan, 4'h0, stuck, tk.hang, halted, busy};
				ACS_RESULT_ADDR: next_prdata = {20'h0, result};
				default: next_prdata = WORD_ZERO;
			endcase
		end
	end

	// ==========================================================
	// Conversion sequencer
	always_comb
	begin
		repeat_mode = conversion_sequence_mode != ACS_SINGLE;
		trig_rise = trig_level == 1'b0 && trig_sync[2] == trig_sync[1] && trig_sync[1];
		next_trig_level = (trig_sync[2] == trig_sync[1]) ? trig_sync[1] : trig_level;
		start_req = trig_timer ? (trig_rise && armed) : software_start_bit;
		next_state = state;
		next_cnt = cnt;
		next_chan = chan;
		next_halted = halted;
		next_stuck = stuck;
		next_hw_used = hw_used || (trig_rise && trig_timer);
		next_armed = armed;
		next_result = result;
		next_conv_done = 1'b0;
		next_sc = sc_wr;
		// Enable low re-arms the timer path for the next trigger.
		if (!conv_enable_bit)
			next_armed = 1'b1;
		// Clearing both power and enable is the recovery path; a start written while both are clear is dropped.
		if (!conv_enable_bit && !converter_power_bit)
		begin
			next_halted = 1'b0;
			next_stuck = 1'b0;
			next_hw_used = 1'b0;
			next_sc = 1'b0;
		end
		// Enable and start in one write, with the software source chosen after a hardware-triggered run, wedge busy.
		// The sets follow the recovery clears so that an event in the same cycle wins.
		if (wr && paddr == ACS_CTRL_ADDR && !pwdata[CTRL_TRIG_BIT] && hw_used && !conv_enable_bit
			&& pwdata[CTRL_ENABLE_BIT] && pwdata[CTRL_START_BIT])
			next_stuck = 1'b1;
		if (pw_toggle && state != ACS_IDLE && repeat_mode)
			next_halted = 1'b1;
		case (state)
			ACS_IDLE:
			begin
				if (start_req && conv_enable_bit && converter_power_bit && !halted && !stuck && !tk.hang)
				begin
					next_state = ACS_SAMPLE;
					next_cnt = 5'h0;
					next_armed = !trig_timer;
					if (!repeat_mode || conversion_sequence_mode == ACS_REPEAT_SINGLE)
						next_chan = chan;
				end
			end
			ACS_SAMPLE:
			begin
				if (tk.tick && !halted)
				begin
					if (cnt + 5'h1 >= SAMPLE_CNT)
					begin
						next_state = ACS_CONVERT;
						next_cnt = 5'h0;
					end
					else
						next_cnt = cnt + 5'h1;
				end
			end
			ACS_CONVERT:
			begin
				if (tk.tick && !halted)
				begin
					if (cnt + 5'h1 >= CONVERT_CNT)
						next_state = ACS_WRITE;
					else
						next_cnt = cnt + 5'h1;
				end
			end
			ACS_WRITE:
			begin
				next_result = adc_data;
				next_conv_done = 1'b1;
				next_state = ACS_IDLE;
				if (conversion_sequence_mode == ACS_SEQUENCE || conversion_sequence_mode == ACS_REPEAT_SEQUENCE)
					next_chan = (chan >= end_chan) ? 4'h0 : chan + 4'h1;
				if (repeat_mode && conv_enable_bit && !trig_timer && !(conversion_sequence_mode == ACS_SEQUENCE
					&& chan >= end_chan))
				begin
					next_state = ACS_SAMPLE;
					next_cnt = 5'h0;
				end
			end
			default: next_state = ACS_IDLE;
		endcase
		// Powering down with conversions disabled abandons the conversion, so recovery starts from idle.
		if (!conv_enable_bit && !converter_power_bit)
			next_state = ACS_IDLE;
		// Start bit self-clears once taken, unless the wedge holds it.
		if (state == ACS_IDLE && next_state == ACS_SAMPLE && !trig_timer)
			next_sc = 1'b0;
		if (next_stuck)
			next_sc = 1'b1;
		next_sample_on = next_state == ACS_SAMPLE && (sample_pulse_select || start_req || state == ACS_SAMPLE);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conv_enable_bit <= 1'b0;
			converter_power_bit <= 1'b0;
			software_start_bit <= 1'b0;
			sample_pulse_select <= 1'b0;
			trig_timer <= 1'b0;
			conversion_sequence_mode <= 2'h0;
			end_chan <= 4'h0;
			converter_clock_select <= 2'h0;
			converter_clock_divider <= 3'h0;
			subclock_gate_off <= 1'b0;
			state <= ACS_IDLE;
			cnt <= 5'h0;
			chan <= 4'h0;
			halted <= 1'b0;
			stuck <= 1'b0;
			hw_used <= 1'b0;
			armed <= 1'b1;
			result <= 12'h000;
			sample_on <= 1'b0;
			conv_done <= 1'b0;
			prdata <= WORD_ZERO;
			pready <= 1'b0;
			pslverr <= 1'b0;
			trig_sync <= 3'h0;
			trig_level <= 1'b0;
		end
		else
		begin
			conv_enable_bit <= next_en;
			converter_power_bit <= next_pw;
			software_start_bit <= next_sc;
			sample_pulse_select <= next_shp;
			trig_timer <= next_trig;
			conversion_sequence_mode <= next_mode;
			end_chan <= next_end;
			converter_clock_select <= next_sel;
			converter_clock_divider <= next_div;
			subclock_gate_off <= next_gate;
			state <= next_state;
			cnt <= next_cnt;
			chan <= next_chan;
			halted <= next_halted;
			stuck <= next_stuck;
			hw_used <= next_hw_used;
			armed <= next_armed;
			result <= next_result;
			sample_on <= next_sample_on;
			conv_done <= next_conv_done;
			prdata <= next_prdata;
			pready <= psel && !penable;
			pslverr <= next_pslverr;
			trig_sync <= {trig_sync[1:0], timer_trig};
			trig_level <= next_trig_level;
		end
	end
endmodule : acs_sequencer

// ==== sim/acs_sequencer_checker.sv ====
`timescale 1ns/1ps
module acs_sequencer_checker
	import acs_pkg::*;
(
	input wire logic        pclk,       // Clock.
	input wire logic        presetn,    // Reset.
	input wire logic        psel,       // Select.
	input wire logic        penable,    // Enable.
	input wire logic        pwrite,     // Direction.
	input wire logic [11:0] paddr,      // Address.
	input wire logic [31:0] pwdata,     // Write data.
	input wire logic [31:0] prdata,     // Read data.
	input wire logic        pready,     // Ready.
	input wire logic        pslverr,    // Error.
	input wire logic        sub_en,     // Subclock tick.
	input wire logic        alt_en,     // Alternate tick.
	input wire logic        timer_trig, // Trigger.
	input wire logic [11:0] adc_data,   // Result in.
	input wire logic        sample_on,  // Sampling.
	input wire logic        conv_done   // Result written.
);
	// ==========================================================
	// Helper: a result may only follow a sampling phase.
	logic seen_sample;
	logic next_seen_sample;
	always_comb
		next_seen_sample = sample_on ? 1'b1 : (conv_done ? 1'b0 : seen_sample);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			seen_sample <= 1'b0;
		else
			seen_sample <= next_seen_sample;
	// ==========================================================
	// Properties.
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_needs_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_unmapped_err: assert property (psel && !penable && paddr >= 12'h010 |=> pslverr)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && !penable && paddr <= 12'h00C && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("mapped access refused");
	a_done_pulse: assert property (conv_done |=> !conv_done)
		else $error("done longer than one cycle");
	a_done_after_sample: assert property (conv_done |-> seen_sample)
		else $error("result without sampling");
	a_done_not_sampling: assert property (conv_done |-> !sample_on)
		else $error("result during sampling");
endmodule : acs_sequencer_checker
bind acs_sequencer acs_sequencer_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .sub_en, .alt_en, .timer_trig, .adc_data, .sample_on, .conv_done);

// ==== sim/acs_sequencer_test.sv ====
`timescale 1ns/1ps
module acs_sequencer_test
	import acs_pkg::*;
;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} acs_row_t;
	logic        pclk, presetn, psel, penable, pwrite, sub_en, alt_en, timer_trig, sub_run;
	logic        pready, pslverr, sample_on, conv_done, er;
	logic [11:0] paddr, adc_data;
	logic [31:0] pwdata, prdata, rd;
	int          num_errors, check_count;
	acs_row_t    rows [5];
	acs_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .sub_en, .alt_en, .timer_trig, .adc_data, .sample_on, .conv_done);
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Both tick sources pulse every other cycle; stopping sub_run shows whether the subsystem clock is the one chosen.
	always @(posedge pclk)
	begin
		alt_en <= ~alt_en;
		sub_en <= sub_run & ~sub_en;
	end
	task close_out;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (n = 0; n < 20 && pready !== 1'b1; n++)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			chk(32'h0, 32'h1);
		@(posedge pclk);
	endtask : apb
	task st(input logic [3:0] m, input logic [3:0] e);
		apb(1'b0, ACS_STATUS_ADDR, 32'h0);
		chk({28'h0, rd[3:0] & m}, {28'h0, e});
	endtask : st
	task wdone(input int lim, input logic exp);
		int n;
		logic g;
		g = 1'b0;
		for (n = 0; n < lim && !g; n++)
		begin
			@(posedge pclk);
			g = (conv_done === 1'b1);
		end
		chk({31'h0, g}, {31'h0, exp});
	endtask : wdone
	task start3;
		apb(1'b1, ACS_CTRL_ADDR, 32'h2);
		apb(1'b1, ACS_CTRL_ADDR, 32'h3);
		apb(1'b1, ACS_CTRL_ADDR, 32'h7);
	endtask : start3
	initial
	begin
		{presetn, psel, penable, pwrite, sub_en, alt_en, timer_trig, paddr, pwdata} = '0;
		sub_run = 1'b1;
		adc_data = 12'hA5C;
		rows = '{'{0, ACS_STATUS_ADDR, 0, 0, 0}, '{0, ACS_RESULT_ADDR, 0, 0, 0}, '{0, 12'h010, 0, 0, 1},
			'{1, 12'h010, 32'hFFFFFFFF, 0, 1}, '{0, 12'hFFC, 0, 0, 1}};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i])
		begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk({31'h0, er}, {31'h0, rows[i].e});
			if (!rows[i].w)
				chk(rd, rows[i].r);
		end
		$display("table done");
		apb(1'b1, ACS_CLK_ADDR, 32'h0);
		st(4'h1, 4'h0);
		start3;
		wdone(100, 1'b1);
		apb(1'b0, ACS_RESULT_ADDR, 32'h0);
		chk(rd, 32'h00000A5C);
		st(4'hF, 4'h0);
		$display("single done");
		apb(1'b1, ACS_CTRL_ADDR, 32'h22);
		apb(1'b1, ACS_CTRL_ADDR, 32'h23);
		apb(1'b1, ACS_CTRL_ADDR, 32'h27);
		for (int n = 0; n < 50 && sample_on !== 1'b1; n++)
			@(posedge pclk);
		apb(1'b1, ACS_CTRL_ADDR, 32'h21);
		st(4'h2, 4'h2);
		wdone(150, 1'b0);
		apb(1'b1, ACS_CTRL_ADDR, 32'h0);
		st(4'hF, 4'h0);
		start3;
		wdone(100, 1'b1);
		$display("halt done");
		apb(1'b1, ACS_CTRL_ADDR, 32'h42);
		apb(1'b1, ACS_CTRL_ADDR, 32'h43);
		timer_trig <= 1'b1;
		repeat (4) @(posedge pclk);
		timer_trig <= 1'b0;
		wdone(100, 1'b1);
		apb(1'b1, ACS_CTRL_ADDR, 32'h2);
		apb(1'b1, ACS_CTRL_ADDR, 32'h7);
		st(4'hF, 4'h9);
		wdone(150, 1'b0);
		apb(1'b0, ACS_CTRL_ADDR, 32'h0);
		chk({31'h0, rd[2]}, 32'h1);
		apb(1'b1, ACS_CTRL_ADDR, 32'h0);
		st(4'hF, 4'h0);
		start3;
		wdone(100, 1'b1);
		$display("stuck done");
		apb(1'b1, ACS_CTRL_ADDR, 32'h0);
		apb(1'b1, ACS_CLK_ADDR, 32'h3);
		sub_run <= 1'b0;
		start3;
		wdone(150, 1'b0);
		sub_run <= 1'b1;
		wdone(100, 1'b1);
		$display("clock select done");
		apb(1'b1, ACS_CTRL_ADDR, 32'h0);
		apb(1'b1, ACS_CLK_ADDR, 32'h133);
		apb(1'b1, ACS_CLK_ADDR, 32'h130);
		st(4'h4, 4'h0);
		apb(1'b1, ACS_CLK_ADDR, 32'h123);
		apb(1'b1, ACS_CLK_ADDR, 32'h120);
		st(4'h4, 4'h4);
		apb(1'b1, ACS_CTRL_ADDR, 32'h0);
		st(4'h4, 4'h4);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		st(4'hF, 4'h0);
		$display("hang done");
		close_out;
	end
	// The whole run needs well under 5000 cycles.
	initial
	begin
		#500000;
		num_errors++;
		close_out;
	end
endmodule : acs_sequencer_test
